// *** pcid_chk.sv ***
/* Port-level checker for pcid_top.
   Assumes one AHB-Lite master and a bind onto every pcid_top. */
`timescale 1ns/1ps
module pcid_chk (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic [7:0]  PINS_I,
    input wire logic        SLEEP_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        CHANGE_IRQ_O,
    input wire logic        WAKE_O,
    input wire logic        IRQ_O
);
    // ****
    // accepted address phases
    // ****
    wire acc = HSEL_I & HREADY_I & HTRANS_I[1];
    wire wr  = acc & HWRITE_I;
    wire rd  = acc & ~HWRITE_I;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // sticky outputs only drop after a write has landed
    ready_zero_wait_a: assert property (HREADYOUT_O) else $error("ready low");
    resp_okay_a: assert property (!HRESP_O) else $error("error response");
    wake_gate_a: assert property (WAKE_O == (SLEEP_I && CHANGE_IRQ_O))
        else $error("wake mismatch");
    flag_sticky_a: assert property ($fell(CHANGE_IRQ_O) |-> $past(wr, 2))
        else $error("request dropped without write");
    edge_latency_a: assert property ($rose(CHANGE_IRQ_O) |->
        $past(wr, 2) || $past(PINS_I, 3) != $past(PINS_I, 4)) else $error("request early");
    irq_sticky_a: assert property ($fell(IRQ_O) |-> $past(wr, 2))
        else $error("irq dropped without write");
    rdata_hold_a: assert property (!rd |=> $stable(HRDATA_O)) else $error("rdata moved");
    unmapped_zero_a: assert property (rd && HADDR_I[7:0] == 8'h18 |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
endmodule : pcid_chk

bind pcid_top pcid_chk i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PINS_I(PINS_I),
    .SLEEP_I(SLEEP_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CHANGE_IRQ_O(CHANGE_IRQ_O),
    .WAKE_O(WAKE_O), .IRQ_O(IRQ_O));

// *** pcid_edge.sv ***
/*
 * Per-pin edge detectors and sticky change flags.
 * Assumes pins are synchronous to CLK_I; a two-stage sync still guards them.
 */
`timescale 1ns/1ps
module pcid_edge (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic [7:0] pins_i,
    pcid_if.det         bus
);

    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] prev_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    wire  [7:0] rise_hit;
    wire  [7:0] fall_hit;
    wire  [7:0] edge_hit;

    // ****************************************************************
    // sampling
    // ****************************************************************
    // sync1 feeds only sync2, prev holds the earlier settled sample
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= pcid_pkg::PIN_RESET;
            sync2_reg <= pcid_pkg::PIN_RESET;
            prev_reg  <= pcid_pkg::PIN_RESET;
        end else begin
            sync1_reg <= pins_i;    // R14
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // edge pulses, one cycle per edge
    assign rise_hit = sync2_reg & ~prev_reg & bus.rise_en;   // R2 R14
    assign fall_hit = ~sync2_reg & prev_reg & bus.fall_en;   // R3 R14
    assign edge_hit = rise_hit | fall_hit;                   // R4

    // set beats write so a racing edge is never lost
    assign flags_next = (bus.flag_wr ? bus.flag_wr_data : flags_reg) | edge_hit; // R7 R13

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= pcid_pkg::PIN_RESET;   // R13
        end else begin
            flags_reg <= flags_next;             // R5 R1
        end
    end

    assign bus.flags    = flags_reg;
    assign bus.any_edge = |edge_hit;

endmodule : pcid_edge

// *** pcid_if.sv ***
/*
 * Interface between the register slave and the edge detector.
 * Assumes both sides share CLK_I.
 */
`timescale 1ns/1ps
interface pcid_if;
    logic [7:0] rise_en;
    logic [7:0] fall_en;
    logic [7:0] flags;
    logic [7:0] flag_wr_data;
    logic       flag_wr;
    logic       any_edge;

    modport regs (output rise_en, output fall_en, output flag_wr_data, output flag_wr,
                  input flags, input any_edge);
    modport det  (input rise_en, input fall_en, input flag_wr_data, input flag_wr,
                  output flags, output any_edge);
endinterface : pcid_if

// *** pcid_pins_model.sv ***
/* Far-side driver of the monitored port pins.
   Assumes push-pull levels changed just after a clock edge. */
`timescale 1ns/1ps
module pcid_pins_model (
    input  wire logic       clk_i,
    output logic      [7:0] pins_o
);
    initial pins_o = 8'h00;
    // levels only, never released: the pins are driven inputs
    task set_pins(input logic [7:0] v);
        @(posedge clk_i);
        pins_o <= v;
    endtask : set_pins
endmodule : pcid_pins_model

// *** pcid_pkg.sv ***
/*
 * Constants for the eight-pin change detector: register offsets, field
 * positions, reset values and bus encodings.
 * Assumes an AHB-Lite register bus with 32-bit data and a 100 MHz clock.
 */
// What this block does
// R1 - master enable clear: edges still detected and flagged, no CHANGE_IRQ_O request; the edge status bit still drives IRQ_O
// R2 - each of eight pins has rising detector gated by its rise enable bit
// R3 - each pin has falling detector gated by its fall enable bit
// R4 - both enables set: either polarity on that pin is detected and flagged
// R5 - enabled edge sets pin flag; CHANGE_IRQ_O raised only with master enable set, the IRQ_O edge status bit whatever it says
// R6 - summary flag is read-only OR of all eight pin flags
// R7 - software writes zero to clear; edge in same cycle keeps flag set
// R8 - software clears only bits already seen set, using masking writes
// R9 - in sleep, enabled edge wakes device when master enable set
// R10 - flags updated in sleep before first instruction after wake
// R11 - rise enable register: eight RW bits, reset zero, zero disables
// R12 - fall enable register: eight RW bits, reset zero, zero disables
// R13 - flag register: eight RW bits, reset zero, set by hardware on enabled edge
// R14 - pins synchronised and compared to previous sample, one pulse per edge
package pcid_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] RISE_EN_OFF   = 8'h00;
    localparam logic [7:0] FALL_EN_OFF   = 8'h04;
    localparam logic [7:0] FLAGS_OFF     = 8'h08;
    localparam logic [7:0] CORE_CTL_OFF  = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFF  = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFF  = 8'h14;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int          NUM_PINS       = 8;
    localparam int          MASTER_EN_BIT  = 3;  // in core_irq_control
    localparam int          SUMMARY_BIT    = 0;  // in core_irq_control
    localparam int          SLEEP_BIT      = 1;  // in core_irq_control
    localparam int          EV_EDGE_BIT    = 0;  // in irq status/mask
    localparam int          EV_WAKE_BIT    = 1;
    localparam int          NUM_EVENTS     = 2;
    localparam logic [7:0]  PIN_RESET      = 8'h00;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : pcid_pkg

// *** pcid_top.sv ***
/*
 * Pin change interrupt detector: AHB-Lite register slave, master enable,
 * summary flag, sleep wake and a masked interrupt line.
 * Assumes a single AHB-Lite master, word transfers, CLK_I at 100 MHz.
 */
`timescale 1ns/1ps
module pcid_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic [7:0]  PINS_I,
    input  wire logic        SLEEP_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             CHANGE_IRQ_O,
    output logic             WAKE_O,
    output logic             IRQ_O
);

    pcid_if link ();

    logic [7:0]  rise_reg;
    logic [7:0]  fall_reg;
    logic        master_en_reg;
    logic [1:0]  stat_reg;
    logic [1:0]  mask_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  stat_next;
    wire         addr_phase;
    wire         summary;
    wire         wake_ev;
    wire         wr_flags;
    wire         wr_core;
    wire         wr_stat;
    wire         wr_mask;
    wire  [31:0] rd_mux;
    wire  [1:0]  events;

    // ****************************************************************
    // detector
    // ****************************************************************
    pcid_edge u_edge (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .pins_i  (PINS_I),
        .bus     (link.det)
    );

    assign link.rise_en      = rise_reg;      // R2
    assign link.fall_en      = fall_reg;      // R3
    assign link.flag_wr      = wr_flags;
    assign link.flag_wr_data = HWDATA_I[7:0]; // R8

    // summary and request; flags run whatever the master enable says
    assign summary      = |link.flags;                  // R6
    assign CHANGE_IRQ_O = summary & master_en_reg;      // R1 R5
    // wake is combinational so flags already hold the edge when core resumes
    assign wake_ev      = SLEEP_I & master_en_reg & link.any_edge; // R9 R10
    assign WAKE_O       = SLEEP_I & CHANGE_IRQ_O;       // R9

    // ****************************************************************
    // AHB-Lite slave, zero wait states
    // ****************************************************************
    assign addr_phase = HSEL_I & HREADY_I & HTRANS_I[1];
    assign wr_flags   = wr_pend_reg & (wr_addr_reg == pcid_pkg::FLAGS_OFF);
    assign wr_core    = wr_pend_reg & (wr_addr_reg == pcid_pkg::CORE_CTL_OFF);
    assign wr_stat    = wr_pend_reg & (wr_addr_reg == pcid_pkg::IRQ_STAT_OFF);
    assign wr_mask    = wr_pend_reg & (wr_addr_reg == pcid_pkg::IRQ_MASK_OFF);
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    // read decode; unmapped addresses read zero
    assign rd_mux =
        (HADDR_I[7:0] == pcid_pkg::RISE_EN_OFF)  ? {24'h000000, rise_reg} :
        (HADDR_I[7:0] == pcid_pkg::FALL_EN_OFF)  ? {24'h000000, fall_reg} :
        (HADDR_I[7:0] == pcid_pkg::FLAGS_OFF)    ? {24'h000000, link.flags} :
        (HADDR_I[7:0] == pcid_pkg::CORE_CTL_OFF) ?
            {28'h0000000, master_en_reg, 1'b0, SLEEP_I, summary} :
        (HADDR_I[7:0] == pcid_pkg::IRQ_STAT_OFF) ? {30'h0, stat_reg} :
        (HADDR_I[7:0] == pcid_pkg::IRQ_MASK_OFF) ? {30'h0, mask_reg} :
        pcid_pkg::RDATA_RESET;

    // address phase capture
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= pcid_pkg::RDATA_RESET;
        end else begin
            wr_pend_reg <= addr_phase & HWRITE_I;
            if (addr_phase) begin
                wr_addr_reg <= HADDR_I[7:0];
            end
            if (addr_phase && !HWRITE_I) begin
                rdata_reg <= rd_mux;
            end
        end
    end
    assign HRDATA_O = rdata_reg;

    // enable registers, reset to zero on every reset
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rise_reg      <= pcid_pkg::PIN_RESET;  // R11
            fall_reg      <= pcid_pkg::PIN_RESET;  // R12
            master_en_reg <= 1'b0;
            mask_reg      <= 2'h0;                  // no unknown mask reaching the irq line
        end else begin
            if (wr_pend_reg && wr_addr_reg == pcid_pkg::RISE_EN_OFF) begin
                rise_reg <= HWDATA_I[7:0];          // R11
            end
            if (wr_pend_reg && wr_addr_reg == pcid_pkg::FALL_EN_OFF) begin
                fall_reg <= HWDATA_I[7:0];          // R12
            end
            if (wr_core) begin
                master_en_reg <= HWDATA_I[pcid_pkg::MASTER_EN_BIT];
            end
            if (wr_mask) begin
                mask_reg <= HWDATA_I[1:0];
            end
        end
    end

    // ****************************************************************
    // interrupt status: write one to clear, set wins
    // ****************************************************************
    assign events = {wake_ev, link.any_edge};
    always_comb begin
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~HWDATA_I[1:0];
        end
        stat_next = stat_next | events;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stat_reg <= 2'h0;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // level request while any unmasked status bit stands
    assign IRQ_O = |(stat_reg & mask_reg);

endmodule : pcid_top

// *** tb.sv ***
/* Self-checking bench for pcid_top.
   Assumes the pins model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic        clk, rst_n, slp, hsel, hwrite, rdy, resp, chg, wake, irq;
    logic [1:0]  htrans;
    logic [7:0]  pins;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          failures = 0;
    int          comparisons = 0;
    pcid_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .PINS_I(pins), .SLEEP_I(slp),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(hrdata),
        .HREADYOUT_O(rdy), .HRESP_O(resp), .CHANGE_IRQ_O(chg), .WAKE_O(wake), .IRQ_O(irq));
    pcid_pins_model i_pins (.clk_i(clk), .pins_o(pins));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****
    // bus and wait helpers
    // ****
    // no wait limit here: only the watchdog ends a stalled transfer
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= pcid_pkg::HTRANS_NONSEQ; haddr <= {24'h0, a}; hwrite <= w;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    // three edges to flag, one spare for the output to settle
    task pin_edge(input logic [7:0] v);
        i_pins.set_pins(v);
        repeat (4) @(posedge clk);
    endtask : pin_edge
    // ****
    // scenarios
    // ****
    task t_reset;
        bus(0, pcid_pkg::RISE_EN_OFF, 0); `CHK(rd, 32'h0)
        bus(0, pcid_pkg::FALL_EN_OFF, 0); `CHK(rd, 32'h0)
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h0)
        bus(0, 8'h18, 0); `CHK(rd, 32'h0)
        bus(1, pcid_pkg::IRQ_MASK_OFF, 32'h3);
        bus(1, pcid_pkg::RISE_EN_OFF, 32'hA5);
        bus(1, pcid_pkg::FALL_EN_OFF, 32'h5A);
        bus(0, pcid_pkg::RISE_EN_OFF, 0); `CHK(rd, 32'hA5)
        bus(0, pcid_pkg::FALL_EN_OFF, 0); `CHK(rd, 32'h5A)
    endtask : t_reset
    task t_edges;
        pin_edge(8'hFF);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'hA5)
        `CHK(chg, 1'b0)
        bus(0, pcid_pkg::CORE_CTL_OFF, 0); `CHK(rd, 32'h1)
        bus(1, pcid_pkg::FLAGS_OFF, 0);
        pin_edge(8'h00);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h5A)
        bus(1, pcid_pkg::FLAGS_OFF, 0);
        bus(1, pcid_pkg::RISE_EN_OFF, 32'hFF);
        bus(1, pcid_pkg::FALL_EN_OFF, 32'hFF);
        pin_edge(8'h0F);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h0F)
        bus(1, pcid_pkg::FLAGS_OFF, 0);
        pin_edge(8'h00);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h0F)
    endtask : t_edges
    task t_master;
        // one more edge so the landed write is visible, not its old value
        bus(1, pcid_pkg::CORE_CTL_OFF, 32'h8);
        @(posedge clk);
        `CHK(chg, 1'b1)
        `CHK(irq, 1'b1)
        bus(1, pcid_pkg::IRQ_STAT_OFF, 32'h3);
        @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1, pcid_pkg::FLAGS_OFF, 0);
        @(posedge clk);
        `CHK(chg, 1'b0)
    endtask : t_master
    // edge lands at the same edge as the clearing write
    task t_race;
        i_pins.set_pins(8'h10);
        @(posedge clk);
        bus(1, pcid_pkg::FLAGS_OFF, 0);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h10)
        // a later edge survives a clear of only the bit already seen
        pin_edge(8'h18);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h18)
        bus(1, pcid_pkg::FLAGS_OFF, rd & ~32'h10);
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h08)
        bus(1, pcid_pkg::FLAGS_OFF, 0);
    endtask : t_race
    task t_sleep;
        slp <= 1'b1;
        pin_edge(8'h38);
        `CHK(wake, 1'b1)
        bus(0, pcid_pkg::FLAGS_OFF, 0); `CHK(rd, 32'h20)
        bus(0, pcid_pkg::IRQ_STAT_OFF, 0); `CHK(rd, 32'h3)
        slp <= 1'b0;
        bus(1, pcid_pkg::CORE_CTL_OFF, 0);
        @(posedge clk);
        `CHK(chg, 1'b0)
    endtask : t_sleep
    task summarize;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        rst_n = 1'b0; slp = 1'b0; hsel = 1'b0; htrans = 2'h0;
        haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset; t_edges; t_master; t_race; t_sleep;
        summarize;
    end
    // cut a hang well beyond the hundred or so cycles needed
    initial begin
        #100us;
        failures++;
        summarize;
    end
endmodule : tb
